/* design/rpd_crc.sv */
// module: two-byte frame check sequence engine, one byte per enable
`timescale 1ns/1ps
`default_nettype none
module rpd_crc
  import rpd_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  rpd_crc_if.eng    bus
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // **************************************************
  // byte update, lsb first
  // **************************************************
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : crc_byte

  // next value: clear wins over a byte
  always_comb begin
    crc_d = crc_q;
    if (bus.clr) begin
      crc_d = CRC_INIT;
    end else if (bus.en) begin
      crc_d = crc_byte(crc_q, bus.data);
    end
  end

  // register
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      crc_q <= CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign bus.crc = crc_q;
endmodule : rpd_crc
`default_nettype wire

/* design/rpd_crc_if.sv */
// interface: byte stream into a check sequence engine and its result
`timescale 1ns/1ps
`default_nettype none
interface rpd_crc_if;
  logic        clr;
  logic        en;
  logic [7:0]  data;
  logic [15:0] crc;
  modport eng  (input clr, input en, input data, output crc);
  modport user (output clr, output en, output data, input crc);
endinterface : rpd_crc_if
`default_nettype wire

/* design/rpd_pkg.sv */
// package: constants and types of the radio packet data path
package rpd_pkg;
  localparam int          PRE_LEN     = 4;          // preamble bytes
  localparam logic [7:0]  PRE_BYTE    = 8'h00;
  localparam logic [7:0]  SFD_BYTE    = 8'ha7;
  localparam logic [6:0]  MAX_PAY     = 7'h7d;      // 125 payload bytes
  localparam logic [6:0]  FCS_LEN     = 7'h02;
  localparam logic [6:0]  PAY_LAST    = 7'h03;      // length minus this is the last payload index
  localparam int          AW          = 7;
  localparam int          RAM_DEP     = 128;
  localparam logic [6:0]  LQI_IDX     = 7'h7f;      // ram slot holding link quality
  localparam logic [15:0] CRC_POLY    = 16'h8408;   // reflected ccitt polynomial
  localparam logic [15:0] CRC_INIT    = 16'h0000;
  localparam logic [15:0] CRC_GOOD    = 16'h0000;   // residue over data plus fcs
  localparam int          CNT_W       = 24;
  localparam int          CLK_MHZ     = 250;
  localparam int          LQI_US      = 64;
  localparam int          CCA_US      = 128;
  localparam int          LQI_CYC_DEF = LQI_US * CLK_MHZ;
  localparam int          CCA_CYC_DEF = CCA_US * CLK_MHZ;
  localparam logic [2:0]  FCS_HI      = 3'h1;
  localparam logic [2:0]  FCS_END     = 3'h2;

  typedef enum logic [1:0] {R_HUNT, R_LEN, R_PAY} rpd_rx_st_t;
  typedef enum logic [2:0] {T_IDLE, T_PRE, T_SFD, T_LEN, T_PAY, T_FCS} rpd_tx_st_t;
endpackage : rpd_pkg

/* design/rpd_top.sv */
// module: packet data path between modem byte link and host
`timescale 1ns/1ps
`default_nettype none
// Contract
// - energy integrated over interval gives channel assessment
// - parse preamble, sfd, length; store payload, fcs
// - check received fcs, give pass or fail
// - link quality over 64 us, stored in ram
// - packet mode: one interrupt per received packet
// - streaming mode: interrupt per received word
// - transmit from ram or host words, framed
// - packet mode: interrupt when frame fully sent
// - streaming transmit: interrupt whenever next word wanted
// - preamble, sfd and length precede payload
// - payload at most 125 bytes
// - append two-byte check sequence for transmit
module rpd_top
  import rpd_pkg::*;
#(
  parameter int LQI_CYC = LQI_CYC_DEF,
  parameter int CCA_CYC = CCA_CYC_DEF
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_lnk_clk,
  input  wire logic        i_lnk_valid,
  input  wire logic [7:0]  i_lnk_byte,
  input  wire logic [7:0]  i_energy,
  input  wire logic        i_stream_mode,
  input  wire logic        i_cca_req,
  input  wire logic [7:0]  i_cca_thresh,
  input  wire logic        i_tx_wr,
  input  wire logic [6:0]  i_tx_addr,
  input  wire logic [7:0]  i_tx_data,
  input  wire logic        i_tx_start,
  input  wire logic [6:0]  i_tx_len,
  input  wire logic        i_host_wr,
  input  wire logic [15:0] i_host_word,
  input  wire logic [6:0]  i_ram_addr,
  input  wire logic        i_irq_ack,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_byte,
  output logic             o_irq,
  output logic [15:0]      o_rx_word,
  output logic [6:0]       o_rx_len,
  output logic             o_crc_ok,
  output logic [7:0]       o_lqi,
  output logic [7:0]       o_ram_data,
  output logic             o_cca_done,
  output logic             o_cca_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  rpd_crc_if rcrc ();
  rpd_crc_if tcrc ();
  rpd_crc u_rcrc (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(rcrc));
  rpd_crc u_tcrc (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(tcrc));

  logic [7:0]  rx_ram [RAM_DEP];
  logic [7:0]  tx_ram [RAM_DEP];
  logic [9:0]  s1_q, s2_q;
  logic        prev_q, lnk_rise, rx_stb;
  logic [7:0]  lnk_byte;
  rpd_rx_st_t  rx_q, rx_d;
  logic [2:0]  pre_q, pre_d;
  logic [6:0]  len_q, len_d, ridx_q, ridx_d, rlen_q, rlen_d;
  logic        fin_q, fin_d, wev_q, wev_d, ok_q, ok_d, ram_we, sfd_hit;
  logic [15:0] word_q, word_d, rxw_q, rxw_d;
  logic        lrun_q, lrun_d, crun_q, crun_d, cdone_q, cdone_d, cbusy_q, cbusy_d;
  logic [CNT_W-1:0] lcnt_q, lcnt_d, ccnt_q, ccnt_d;
  logic [31:0] lsum_q, lsum_d, csum_q, csum_d;
  logic [7:0]  lqi_q, lqi_d;
  logic        lqi_we;
  rpd_tx_st_t  tx_q, tx_d;
  logic [2:0]  tcnt_q, tcnt_d;
  logic [6:0]  tidx_q, tidx_d, tlen_q, tlen_d;
  logic        tstr_q, tstr_d, whi_q, whi_d, wfull_q, wfull_d, tv_q, tv_d;
  logic        need_q, need_d, tdone_q, tdone_d, irq_q;
  logic [7:0]  tb_q, tb_d, pay_b, rd_q;
  logic [15:0] wbuf_q, wbuf_d;

  // **************************************************
  // link inputs: two flops, then edge find
  // **************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      s1_q   <= '0;
      s2_q   <= '0;
      prev_q <= 1'b0;
    end else begin
      s1_q   <= {i_lnk_clk, i_lnk_valid, i_lnk_byte};
      s2_q   <= s1_q;
      prev_q <= s2_q[9];
    end
  end
  assign lnk_rise = s2_q[9] & ~prev_q;
  assign rx_stb   = lnk_rise & s2_q[8];
  assign lnk_byte = s2_q[7:0];

  // **************************************************
  // receive framing
  // **************************************************
  always_comb begin
    rx_d      = rx_q;
    pre_d     = pre_q;
    len_d     = len_q;
    ridx_d    = ridx_q;
    word_d    = word_q;
    rxw_d     = rxw_q;
    rlen_d    = rlen_q;
    ok_d      = ok_q;
    fin_d     = 1'b0;
    wev_d     = 1'b0;
    ram_we    = 1'b0;
    sfd_hit   = 1'b0;
    rcrc.clr  = 1'b0;
    rcrc.en   = 1'b0;
    rcrc.data = lnk_byte;
    if (fin_q) begin
      ok_d   = (rcrc.crc == CRC_GOOD);
      rlen_d = len_q;
    end
    if (rx_stb) begin
      case (rx_q)
        R_HUNT: begin
          if (lnk_byte == PRE_BYTE) begin
            pre_d = (pre_q == 3'(PRE_LEN)) ? pre_q : pre_q + 3'h1;
          end else if (lnk_byte == SFD_BYTE && pre_q == 3'(PRE_LEN)) begin
            rx_d    = R_LEN;
            sfd_hit = 1'b1;
          end else begin
            pre_d = '0;
          end
        end
        R_LEN: begin
          pre_d    = '0;
          len_d    = lnk_byte[6:0];
          ridx_d   = '0;
          rcrc.clr = 1'b1;
          if (lnk_byte[7] || lnk_byte[6:0] > MAX_PAY + FCS_LEN || lnk_byte[6:0] < FCS_LEN) begin
            rx_d = R_HUNT;
          end else begin
            rx_d = R_PAY;
          end
        end
        R_PAY: begin
          ram_we  = 1'b1;
          rcrc.en = 1'b1;
          ridx_d  = ridx_q + 7'h01;
          word_d  = ridx_q[0] ? {lnk_byte, word_q[7:0]} : {8'h00, lnk_byte};
          wev_d   = i_stream_mode & (ridx_q[0] | (ridx_q == len_q - 7'h01));
          if (ridx_q == len_q - 7'h01) begin
            rx_d  = R_HUNT;
            fin_d = 1'b1;
          end
        end
        default: rx_d = R_HUNT;
      endcase
    end
    if (wev_d) begin
      rxw_d = word_d;
    end
  end

  // **************************************************
  // energy integration: link quality and channel check
  // **************************************************
  always_comb begin
    lrun_d  = lrun_q;
    lcnt_d  = lcnt_q;
    lsum_d  = lsum_q;
    lqi_d   = lqi_q;
    lqi_we  = 1'b0;
    crun_d  = crun_q;
    ccnt_d  = ccnt_q;
    csum_d  = csum_q;
    cdone_d = cdone_q;
    cbusy_d = cbusy_q;
    if (sfd_hit) begin
      lrun_d = 1'b1;
      lcnt_d = '0;
      lsum_d = '0;
    end else if (lrun_q) begin
      lsum_d = lsum_q + 32'(i_energy);
      lcnt_d = lcnt_q + 1'b1;
      if (lcnt_q == CNT_W'(LQI_CYC - 1)) begin
        lrun_d = 1'b0;
        lqi_d  = 8'(lsum_d / 32'(LQI_CYC));
        lqi_we = 1'b1;
      end
    end
    if (i_cca_req && !crun_q) begin
      crun_d  = 1'b1;
      ccnt_d  = '0;
      csum_d  = '0;
      cdone_d = 1'b0;
    end else if (crun_q) begin
      csum_d = csum_q + 32'(i_energy);
      ccnt_d = ccnt_q + 1'b1;
      if (ccnt_q == CNT_W'(CCA_CYC - 1)) begin
        crun_d  = 1'b0;
        cdone_d = 1'b1;
        cbusy_d = csum_d > 32'(i_cca_thresh) * 32'(CCA_CYC);
      end
    end
  end

  // **************************************************
  // transmit framing
  // **************************************************
  assign pay_b = tstr_q ? (whi_q ? wbuf_q[15:8] : wbuf_q[7:0]) : tx_ram[tidx_q];
  always_comb begin
    tx_d      = tx_q;
    tcnt_d    = tcnt_q;
    tidx_d    = tidx_q;
    tlen_d    = tlen_q;
    tstr_d    = tstr_q;
    whi_d     = whi_q;
    wfull_d   = wfull_q;
    wbuf_d    = wbuf_q;
    tv_d      = tv_q;
    tb_d      = tb_q;
    need_d    = 1'b0;
    tdone_d   = 1'b0;
    tcrc.clr  = 1'b0;
    tcrc.en   = 1'b0;
    tcrc.data = pay_b;
    if (tx_q != T_IDLE && tstr_q && i_host_wr && !wfull_q) begin
      wbuf_d  = i_host_word;
      wfull_d = 1'b1;
    end
    if (tx_q == T_IDLE && i_tx_start) begin
      tx_d     = T_PRE;
      tcnt_d   = '0;
      tidx_d   = '0;
      whi_d    = 1'b0;
      wfull_d  = 1'b0;
      tlen_d   = i_tx_len;
      tstr_d   = i_stream_mode;
      need_d   = i_stream_mode;
      tcrc.clr = 1'b1;
    end else if (lnk_rise) begin
      case (tx_q)
        T_PRE: begin
          tv_d   = 1'b1;
          tb_d   = PRE_BYTE;
          tcnt_d = tcnt_q + 3'h1;
          if (tcnt_q == 3'(PRE_LEN - 1)) begin
            tx_d = T_SFD;
          end
        end
        T_SFD: begin
          tb_d = SFD_BYTE;
          tx_d = T_LEN;
        end
        T_LEN: begin
          tb_d   = {1'b0, tlen_q};
          tcnt_d = '0;
          tx_d   = (tlen_q <= FCS_LEN) ? T_FCS : T_PAY;
        end
        T_PAY: begin
          tv_d = !tstr_q || wfull_q;
          if (!tstr_q || wfull_q) begin
            tb_d    = pay_b;
            tcrc.en = 1'b1;
            tidx_d  = tidx_q + 7'h01;
            whi_d   = ~whi_q;
            if (tidx_q == tlen_q - PAY_LAST) begin
              tx_d    = T_FCS;
              wfull_d = 1'b0;
            end else if (tstr_q && whi_q) begin
              wfull_d = 1'b0;
              need_d  = 1'b1;
            end
          end
        end
        T_FCS: begin
          tv_d   = tcnt_q != FCS_END;
          tb_d   = (tcnt_q == FCS_HI) ? tcrc.crc[15:8] : tcrc.crc[7:0];
          tcnt_d = tcnt_q + 3'h1;
          if (tcnt_q == FCS_END) begin
            tx_d    = T_IDLE;
            tdone_d = 1'b1;
          end
        end
        default: tv_d = 1'b0;
      endcase
    end
  end

  // **************************************************
  // registers, memories and interrupt flag
  // **************************************************
  always_ff @(posedge i_clk) begin
    if (ram_we) begin
      rx_ram[ridx_q] <= lnk_byte;
    end
    if (lqi_we) begin
      rx_ram[LQI_IDX] <= lqi_d;
    end
    if (i_tx_wr) begin
      tx_ram[i_tx_addr] <= i_tx_data;
    end
  end

  // interrupt: an event in the ack cycle still sets the flag
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rx_q <= R_HUNT;
      tx_q <= T_IDLE;
      {pre_q, len_q, ridx_q, rlen_q, fin_q, wev_q, ok_q, word_q, rxw_q} <= '0;
      {lrun_q, lcnt_q, lsum_q, lqi_q, crun_q, ccnt_q, csum_q, cdone_q, cbusy_q} <= '0;
      {tcnt_q, tidx_q, tlen_q, tstr_q, whi_q, wfull_q, wbuf_q, tv_q, tb_q} <= '0;
      {need_q, tdone_q, irq_q, rd_q} <= '0;
    end else begin
      rx_q <= rx_d;
      tx_q <= tx_d;
      {pre_q, len_q, ridx_q, rlen_q, fin_q, wev_q, ok_q, word_q, rxw_q} <=
        {pre_d, len_d, ridx_d, rlen_d, fin_d, wev_d, ok_d, word_d, rxw_d};
      {lrun_q, lcnt_q, lsum_q, lqi_q, crun_q, ccnt_q, csum_q, cdone_q, cbusy_q} <=
        {lrun_d, lcnt_d, lsum_d, lqi_d, crun_d, ccnt_d, csum_d, cdone_d, cbusy_d};
      {tcnt_q, tidx_q, tlen_q, tstr_q, whi_q, wfull_q, wbuf_q, tv_q, tb_q} <=
        {tcnt_d, tidx_d, tlen_d, tstr_d, whi_d, wfull_d, wbuf_d, tv_d, tb_d};
      {need_q, tdone_q} <= {need_d, tdone_d};
      irq_q <= (irq_q & ~i_irq_ack) | (fin_q & ~i_stream_mode) | wev_q | need_q | tdone_q;
      rd_q  <= rx_ram[i_ram_addr];
    end
  end

  assign {o_tx_valid, o_tx_byte, o_irq, o_rx_word, o_rx_len} = {tv_q, tb_q, irq_q, rxw_q, rlen_q};
  assign {o_crc_ok, o_lqi, o_ram_data, o_cca_done, o_cca_busy} = {ok_q, lqi_q, rd_q, cdone_q, cbusy_q};

  // **************************************************
  // checks
  // **************************************************
  sequence s_last_pkt;
    rx_q == R_PAY && rx_stb && ridx_q == len_q - 7'h01 && !i_stream_mode;
  endsequence
  sequence s_crc_then_irq;
    rx_q == R_HUNT ##1 o_irq;
  endsequence
  AST_RX_STORE: assert property ((rx_q == R_PAY && rx_stb) |=> rx_ram[$past(ridx_q)] == $past(lnk_byte))
    else $error("payload byte not stored");
  AST_RX_BADLEN: assert property ((rx_q == R_LEN && rx_stb && lnk_byte[6:0] < FCS_LEN) |=> rx_q == R_HUNT)
    else $error("bad length accepted");
  AST_CRC_LATCH: assert property (fin_q |=> o_crc_ok == ($past(rcrc.crc) == CRC_GOOD))
    else $error("check result not latched");
  AST_PKT_IRQ: assert property (s_last_pkt |=> s_crc_then_irq)
    else $error("no packet interrupt");
  AST_WORD_IRQ: assert property ((rx_q == R_PAY && rx_stb && ridx_q[0] && i_stream_mode)
    |=> ##1 o_irq && o_rx_word[15:8] == $past(lnk_byte, 2))
    else $error("no word interrupt");
  AST_LQI_END: assert property ((lrun_q && lcnt_q == CNT_W'(LQI_CYC - 1))
    |=> !lrun_q && rx_ram[LQI_IDX] == o_lqi)
    else $error("link quality not stored");
  AST_CCA_END: assert property ((crun_q && ccnt_q == CNT_W'(CCA_CYC - 1)) |=> o_cca_done && !crun_q)
    else $error("channel check not finished");
  AST_TX_SFD: assert property ((tx_q == T_SFD && lnk_rise) |=> o_tx_valid && o_tx_byte == SFD_BYTE)
    else $error("sfd not sent");
  AST_TX_PAY: assert property ((tx_q == T_PAY && lnk_rise && !tstr_q) |=> o_tx_byte == $past(pay_b))
    else $error("payload byte wrong");
  AST_TX_FCS: assert property ((tx_q == T_FCS && lnk_rise && tcnt_q == '0)
    |=> o_tx_byte == $past(tcrc.crc[7:0]))
    else $error("fcs low byte wrong");
  AST_TX_DONE: assert property ((tx_q == T_FCS && lnk_rise && tcnt_q == FCS_END) |=> ##1 o_irq)
    else $error("no transmit done interrupt");
  AST_TX_NEED: assert property ((tx_q == T_IDLE && i_tx_start && i_stream_mode) |=> ##1 o_irq)
    else $error("no word request interrupt");
endmodule : rpd_top
`default_nettype wire

/* test/rpd_modem_model.sv */
// partner model: modem side of the byte link, sends receive frames and collects transmit bytes
`timescale 1ns/1ps
`default_nettype none
module rpd_modem_model (
  input  wire logic       i_run,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_lnk_clk,
  output logic            o_lnk_valid,
  output logic [7:0]      o_lnk_byte
);
  logic       rx_on;
  logic [7:0] got[$];  // transmit bytes seen, in order

  // ************************************************************
  // link clock, stands low outside frames
  // ************************************************************
  initial begin
    o_lnk_clk = 1'b0;
    o_lnk_valid = 1'b0;
    o_lnk_byte = 8'h5a;
    rx_on = 1'b0;
    #3;
    forever begin
      #16;
      o_lnk_clk = (i_run || rx_on) ? ~o_lnk_clk : 1'b0;
    end
  end

  // take transmit bytes half a link period after the rise, once settled
  always @(negedge o_lnk_clk) begin
    if (i_tx_valid === 1'b1) got.push_back(i_tx_byte);
  end

  // send one frame, byte changes at the falling edge only
  task automatic send_frame(input logic [7:0] q[$]);
    rx_on = 1'b1;
    foreach (q[k]) begin
      @(negedge o_lnk_clk);
      o_lnk_byte = q[k];
      o_lnk_valid = 1'b1;
    end
    @(negedge o_lnk_clk);
    o_lnk_valid = 1'b0;
    o_lnk_byte = ~o_lnk_byte;  // released line never keeps the last byte
    rx_on = 1'b0;
  endtask : send_frame
endmodule : rpd_modem_model
`default_nettype wire

/* test/rpd_top_tb.sv */
// testbench: channel check, receive and transmit traffic through the packet data path
`timescale 1ns/1ps
`default_nettype none
module rpd_top_tb
  import rpd_pkg::*;
;
  typedef logic [7:0] rpd_bytes_t[$];
  logic        i_clk, i_rst_b, run, i_lnk_clk, i_lnk_valid, i_stream_mode, i_cca_req, i_tx_wr;
  logic        i_tx_start, i_host_wr, i_irq_ack, o_tx_valid, o_irq, o_crc_ok, o_cca_done, o_cca_busy;
  logic [6:0]  i_tx_addr, i_tx_len, i_ram_addr, o_rx_len;
  logic [7:0]  i_lnk_byte, i_energy, i_cca_thresh, i_tx_data, o_tx_byte, o_lqi, o_ram_data;
  logic [15:0] i_host_word, o_rx_word;
  int          failures, checks_done;

  rpd_top #(.LQI_CYC(32), .CCA_CYC(16)) dut_u (.i_clk, .i_rst_b, .i_lnk_clk, .i_lnk_valid, .i_lnk_byte,
    .i_energy, .i_stream_mode, .i_cca_req, .i_cca_thresh, .i_tx_wr, .i_tx_addr, .i_tx_data, .i_tx_start,
    .i_tx_len, .i_host_wr, .i_host_word, .i_ram_addr, .i_irq_ack, .o_tx_valid, .o_tx_byte, .o_irq,
    .o_rx_word, .o_rx_len, .o_crc_ok, .o_lqi, .o_ram_data, .o_cca_done, .o_cca_busy);
  rpd_modem_model modem_u (.i_run(run), .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte),
    .o_lnk_clk(i_lnk_clk), .o_lnk_valid(i_lnk_valid), .o_lnk_byte(i_lnk_byte));

  // ************************************************************
  // shared helpers
  // ************************************************************
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // bounded wait for the interrupt or the channel check result
  task automatic wait_hi(input bit cca, input int bound);
    int n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while ((cca ? o_cca_done : o_irq) !== 1'b1 && n < bound);
    if ((cca ? o_cca_done : o_irq) !== 1'b1) begin
      failures++;
      $display("BAD wait exp 1 seen 0");
      summarize();
    end
  endtask : wait_hi

  task automatic ack();
    @(posedge i_clk);
    i_irq_ack <= 1'b1;
    @(posedge i_clk);
    i_irq_ack <= 1'b0;
  endtask : ack

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_ram_addr <= a;
    @(posedge i_clk);
    #1;
    check("ram_data", o_ram_data, exp);
  endtask : rd

  // whole frame with check sequence, low byte first; bad flips one bit
  function automatic rpd_bytes_t frame(input rpd_bytes_t pay, input bit bad);
    rpd_bytes_t  q;
    logic [15:0] c;
    repeat (PRE_LEN) q.push_back(PRE_BYTE);
    q.push_back(SFD_BYTE);
    q.push_back(8'(pay.size() + 2));
    c = CRC_INIT;
    foreach (pay[k]) begin
      q.push_back(pay[k]);
      c = c ^ {8'h00, pay[k]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    q.push_back(c[7:0] ^ {7'h00, bad});
    q.push_back(c[15:8]);
    return q;
  endfunction : frame

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic cca(input logic [7:0] e, input logic [7:0] th, input logic exp);
    @(posedge i_clk);
    i_energy <= e;
    i_cca_thresh <= th;
    i_cca_req <= 1'b1;
    @(posedge i_clk);
    i_cca_req <= 1'b0;
    @(posedge i_clk);
    #1;
    check("cca_done", o_cca_done, 1'b0);
    wait_hi(1'b1, 40);
    check("cca_busy", o_cca_busy, exp);
  endtask : cca

  task automatic rx_packet(input rpd_bytes_t pay, input bit bad);
    rpd_bytes_t f;
    f = frame(pay, bad);
    @(posedge i_clk);
    i_stream_mode <= 1'b0;
    i_energy <= 8'h3c;
    modem_u.send_frame(f);
    wait_hi(1'b0, 200);
    check("crc_ok", o_crc_ok, !bad);
    check("rx_len", o_rx_len, pay.size() + 2);
    for (int k = 0; k < f.size() - 6; k++) rd(7'(k), f[k + 6]);
    ack();
    repeat (40) @(posedge i_clk);
    #1;
    check("irq_once", o_irq, 1'b0);
    check("lqi", o_lqi, 8'h3c);
    rd(LQI_IDX, 8'h3c);
  endtask : rx_packet

  // length field below the check sequence size: dropped silently, no interrupt
  task automatic rx_badlen();
    @(posedge i_clk);
    i_stream_mode <= 1'b0;
    modem_u.send_frame({PRE_BYTE, PRE_BYTE, PRE_BYTE, PRE_BYTE, SFD_BYTE, 8'h01, 8'h55, 8'h66});
    repeat (20) @(posedge i_clk);
    #1;
    check("badlen_irq", o_irq, 1'b0);
    check("badlen_len", o_rx_len, 7'h03);
  endtask : rx_badlen

  task automatic rx_stream();
    rpd_bytes_t pay, f;
    pay = {8'h11, 8'h22, 8'h33, 8'h44};
    f = frame(pay, 1'b0);
    @(posedge i_clk);
    i_stream_mode <= 1'b1;
    fork
      modem_u.send_frame(f);
    join_none
    for (int w = 0; w < 3; w++) begin
      wait_hi(1'b0, 200);
      check("rx_word", o_rx_word, {f[2 * w + 7], f[2 * w + 6]});
      ack();
    end
    wait fork;
    repeat (8) @(posedge i_clk);
    #1;
    check("irq_stream_end", o_irq, 1'b0);
  endtask : rx_stream

  task automatic tx_send(input bit strm, input rpd_bytes_t pay);
    rpd_bytes_t f;
    f = frame(pay, 1'b0);
    modem_u.got.delete();
    @(posedge i_clk);
    i_stream_mode <= strm;
    run <= 1'b1;
    i_tx_len <= 7'(pay.size() + 2);
    i_tx_start <= 1'b1;
    @(posedge i_clk);
    i_tx_start <= 1'b0;
    for (int w = 0; strm && w < 2; w++) begin
      wait_hi(1'b0, 300);
      ack();
      @(posedge i_clk);
      i_host_wr <= 1'b1;
      i_host_word <= {w ? 8'h00 : pay[1], pay[2 * w]};
      @(posedge i_clk);
      i_host_wr <= 1'b0;
    end
    wait_hi(1'b0, 1500);
    run <= 1'b0;
    check("tx_count", modem_u.got.size(), f.size());
    foreach (f[k]) check("tx_byte", modem_u.got[k], f[k]);
    ack();
  endtask : tx_send

  task automatic tx_packet();
    rpd_bytes_t pay;
    for (int k = 0; k < MAX_PAY; k++) pay.push_back(8'(k) ^ 8'h3c);
    foreach (pay[k]) begin
      @(posedge i_clk);
      i_tx_wr <= 1'b1;
      i_tx_addr <= 7'(k);
      i_tx_data <= pay[k];
    end
    @(posedge i_clk);
    i_tx_wr <= 1'b0;
    tx_send(1'b0, pay);
  endtask : tx_packet

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {i_rst_b, run, i_stream_mode, i_cca_req, i_tx_wr, i_tx_start, i_host_wr, i_irq_ack} = 8'h00;
    {i_tx_addr, i_tx_len, i_ram_addr} = 21'h000000;
    {i_energy, i_cca_thresh, i_tx_data} = 24'h000000;
    i_host_word = 16'h0000;
    failures = 0;
    checks_done = 0;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1;
    check("irq_reset", o_irq, 1'b0);
    check("tx_valid_reset", o_tx_valid, 1'b0);
    cca(8'h40, 8'h3f, 1'b1);
    cca(8'h40, 8'h40, 1'b0);
    rx_packet({8'h5e, 8'h01, 8'hf0}, 1'b0);
    rx_packet({8'h77}, 1'b1);
    rx_badlen();
    rx_stream();
    tx_packet();
    tx_send(1'b1, {8'ha1, 8'hb2, 8'hc3});
    summarize();
  end
endmodule : rpd_top_tb
`default_nettype wire
